// File: hdl/tceoc_pkg.sv
/*
  Package for the timer channel edge, option and capture/compare-0 logic.
  Holds register indices, field positions, reset values, modes and edge codes.
  Assumes a 32-bit AXI4-Lite register bus; byte address is four times the index.
*/
package tceoc_pkg;

  // Register indices (byte address = index * 4)
  localparam logic [31:0] IDX_CTRL        = 32'hFFFFF590;
  localparam logic [31:0] IDX_CAP_EDGE    = 32'hFFFFF593;
  localparam logic [31:0] IDX_EVT_EDGE    = 32'hFFFFF594;
  localparam logic [31:0] IDX_OPTION      = 32'h0FFFF595;
  localparam logic [31:0] IDX_CCR0        = 32'hFFFFF596;
  localparam logic [31:0] IDX_CCR1        = 32'hFFFFF598;
  localparam logic [31:0] IDX_COUNT       = 32'hFFFFF59E;

  // Field positions
  localparam int CTRL_CE_BIT   = 7;
  localparam int CTRL_OE0_BIT  = 6;
  localparam int CTRL_EEE_BIT  = 5;
  localparam int CTRL_MODE_LSB = 0;
  localparam int EDGE_HI_LSB   = 2;
  localparam int EDGE_LO_LSB   = 0;
  localparam int OPT_CCS1_BIT  = 5;
  localparam int OPT_CCS0_BIT  = 4;
  localparam int OPT_OVF_BIT   = 0;

  // Reset values and counter maximum
  localparam logic [15:0] CCR_RESET  = 16'h0000;
  localparam logic [15:0] CNT_ZERO   = 16'h0000;
  localparam logic [15:0] CNT_MAX    = 16'hFFFF;
  localparam logic [31:0] RD_ZERO    = 32'h00000000;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    MODE_INTERVAL  = 3'b000,
    MODE_EVENT_CNT = 3'b001,
    MODE_TRIG_PULS = 3'b010,
    MODE_ONE_SHOT  = 3'b011,
    MODE_PWM       = 3'b100,
    MODE_FREE_RUN  = 3'b101,
    MODE_PULSE_WID = 3'b110,
    MODE_PROHIB    = 3'b111
  } tceoc_mode_t;

  typedef enum logic [1:0] {
    EDGE_NONE    = 2'b00,
    EDGE_RISING  = 2'b01,
    EDGE_FALLING = 2'b10,
    EDGE_BOTH    = 2'b11
  } tceoc_edge_t;

  typedef enum logic [2:0] {
    SEL_NONE  = 3'b000,
    SEL_CTRL  = 3'b001,
    SEL_CAP   = 3'b010,
    SEL_EVT   = 3'b011,
    SEL_OPT   = 3'b100,
    SEL_CCR0  = 3'b101,
    SEL_CCR1  = 3'b110,
    SEL_COUNT = 3'b111
  } tceoc_sel_t;

  // Control fields
  typedef struct packed {
    logic        counter_enable;
    logic        out0_enable;
    logic        external_event_input_enable;
    tceoc_mode_t timer_mode_field;
  } tceoc_ctrl_t;

  // A pair of two-bit edge fields
  typedef struct packed {
    tceoc_edge_t hi;
    tceoc_edge_t lo;
  } tceoc_edges_t;

endpackage

// File: hdl/tceoc_top.sv
/*
  One timer channel: capture/event/trigger edge selection, option register
  with overflow flag, capture/compare register 0 with its compare shadow.
  Assumes an AXI4-Lite master in the same clock domain and input pins that
  are synchronous to clk (they are still retimed before edge detection).
*/
`timescale 1ns/100ps

module tceoc_top #(
  parameter int CNT_W = 16
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // AXI4-Lite write address
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Timer pins
  input  wire logic        timer_input_zero,
  input  wire logic        timer_input_one,
  output logic             timer_output_zero,
  // Interrupt requests
  output logic             overflow_irq,
  output logic             compare0_irq
);

  initial begin
    if (CNT_W != 16) begin
      $error("tceoc_top supports only a 16-bit counter");
    end
  end

  // Register decode shared by read and write paths
  function automatic tceoc_pkg::tceoc_sel_t reg_decode(input logic [31:0] addr);
    if (addr[1:0] != 2'h0) begin
      reg_decode = tceoc_pkg::SEL_NONE;
    end else if (addr[31:2] == tceoc_pkg::IDX_CTRL[29:0]) begin
      reg_decode = tceoc_pkg::SEL_CTRL;
    end else if (addr[31:2] == tceoc_pkg::IDX_CAP_EDGE[29:0]) begin
      reg_decode = tceoc_pkg::SEL_CAP;
    end else if (addr[31:2] == tceoc_pkg::IDX_EVT_EDGE[29:0]) begin
      reg_decode = tceoc_pkg::SEL_EVT;
    end else if (addr[31:2] == tceoc_pkg::IDX_OPTION[29:0]) begin
      reg_decode = tceoc_pkg::SEL_OPT;
    end else if (addr[31:2] == tceoc_pkg::IDX_CCR0[29:0]) begin
      reg_decode = tceoc_pkg::SEL_CCR0;
    end else if (addr[31:2] == tceoc_pkg::IDX_CCR1[29:0]) begin
      reg_decode = tceoc_pkg::SEL_CCR1;
    end else if (addr[31:2] == tceoc_pkg::IDX_COUNT[29:0]) begin
      reg_decode = tceoc_pkg::SEL_COUNT;
    end else begin
      reg_decode = tceoc_pkg::SEL_NONE;
    end
  endfunction

  // Valid edge test: low code bit rising, high code bit falling
  function automatic logic edge_hit(input tceoc_pkg::tceoc_edge_t sel,
                                    input logic prev, input logic cur);
    edge_hit = (sel[0] & ~prev & cur) | (sel[1] & prev & ~cur);
  endfunction

  tceoc_pkg::tceoc_ctrl_t  ctrl;
  tceoc_pkg::tceoc_edges_t cap_edges;
  tceoc_pkg::tceoc_edges_t evt_edges;
  tceoc_pkg::tceoc_sel_t   wr_sel;
  logic                    reg1_capture_select;
  logic                    reg0_capture_select;
  logic                    overflow_flag;
  logic [CNT_W-1:0]        capture_compare_zero;
  logic [CNT_W-1:0]        capture_compare_one;
  logic [CNT_W-1:0]        compare0_shadow;
  logic [CNT_W-1:0]        count;
  logic [31:0]             aw_addr;
  logic [31:0]             w_data;
  logic [3:0]              w_strb;
  logic                    aw_got;
  logic                    w_got;
  logic                    wr_fire;
  logic [1:0]              in_meta;
  logic [1:0]              in_sync;
  logic [1:0]              in_prev;
  logic                    free_run;
  logic                    pulse_wid;
  logic                    cap_mode;
  logic                    cycle_mode;
  logic                    event_on;
  logic                    trig_on;
  logic                    cap0_take;
  logic                    cap1_take;
  logic                    event_edge;
  logic                    trig_edge;
  logic                    tick;
  logic                    reg0_compare;
  logic                    match0;
  logic                    cnt_clear;
  logic                    ovf_set;
  logic                    ovf_wr_clear;
  logic                    ccr0_wr;

  // Mode decode
  assign free_run   = ctrl.timer_mode_field == tceoc_pkg::MODE_FREE_RUN;
  assign pulse_wid  = ctrl.timer_mode_field == tceoc_pkg::MODE_PULSE_WID;
  assign cycle_mode = ctrl.timer_mode_field <= tceoc_pkg::MODE_PWM;
  assign cap_mode   = free_run | pulse_wid;
  assign event_on   = ctrl.external_event_input_enable |
                      (ctrl.timer_mode_field == tceoc_pkg::MODE_EVENT_CNT);
  assign trig_on    = (ctrl.timer_mode_field == tceoc_pkg::MODE_TRIG_PULS) |
                      (ctrl.timer_mode_field == tceoc_pkg::MODE_ONE_SHOT);

  // retime both pins, keep previous sample
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      in_meta <= 2'h0;
      in_sync <= 2'h0;
      in_prev <= 2'h0;
    end else begin
      in_meta <= {timer_input_one, timer_input_zero};
      in_sync <= in_meta;
      in_prev <= in_sync;
    end
  end

  // input zero capture into register zero
  assign cap0_take  = ctrl.counter_enable & cap_mode &
                      edge_hit(cap_edges.lo, in_prev[0], in_sync[0]) &
                      (pulse_wid | (free_run & reg0_capture_select));
  // input one capture into register one
  assign cap1_take  = ctrl.counter_enable & cap_mode &
                      edge_hit(cap_edges.hi, in_prev[1], in_sync[1]) &
                      (pulse_wid | (free_run & reg1_capture_select));
  // event count edge on input zero
  assign event_edge = event_on & edge_hit(evt_edges.hi, in_prev[0], in_sync[0]);
  assign trig_edge  = ctrl.counter_enable & trig_on &
                      edge_hit(evt_edges.lo, in_prev[0], in_sync[0]);
  // Internal count every clock, external only on its valid edge
  assign tick       = ctrl.counter_enable & (event_on ? event_edge : 1'b1);
  assign reg0_compare = ~pulse_wid & ~(free_run & reg0_capture_select);
  // match on a count step, so a stalled counter matches once
  assign match0     = tick & reg0_compare & (count == compare0_shadow);
  assign cnt_clear  = (match0 & cycle_mode) | (cap0_take & pulse_wid) | trig_edge;
  assign ovf_set    = tick & cap_mode & ~cnt_clear & (count == tceoc_pkg::CNT_MAX);

  // Write-side decode
  assign wr_fire      = aw_got & w_got & ~s_axi_bvalid;
  assign wr_sel       = reg_decode(aw_addr);
  assign ccr0_wr      = wr_fire & (wr_sel == tceoc_pkg::SEL_CCR0) & (&w_strb[1:0]);
  assign ovf_wr_clear = wr_fire & (wr_sel == tceoc_pkg::SEL_OPT) & w_strb[0] &
                        ~w_data[tceoc_pkg::OPT_OVF_BIT];

  // AXI write channels: address and data held independently
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= tceoc_pkg::RESP_OKAY;
      aw_got        <= 1'b0;
      w_got         <= 1'b0;
      aw_addr       <= tceoc_pkg::RD_ZERO;
      w_data        <= tceoc_pkg::RD_ZERO;
      w_strb        <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr       <= s_axi_awaddr;
        aw_got        <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
        w_got        <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_got       <= 1'b0;
        w_got        <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wr_sel == tceoc_pkg::SEL_NONE) ? tceoc_pkg::RESP_SLVERR
                                                        : tceoc_pkg::RESP_OKAY;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Byte-wide configuration registers; reserved bits are dropped
  // fields are taken as written, software keeps them stable
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl                <= '0;
      cap_edges           <= '0;
      evt_edges           <= '0;
      reg1_capture_select <= 1'b0;
      reg0_capture_select <= 1'b0;
    end else if (wr_fire && w_strb[0]) begin
      if (wr_sel == tceoc_pkg::SEL_CTRL) begin
        ctrl.counter_enable              <= w_data[tceoc_pkg::CTRL_CE_BIT];
        ctrl.out0_enable                 <= w_data[tceoc_pkg::CTRL_OE0_BIT];
        ctrl.external_event_input_enable <= w_data[tceoc_pkg::CTRL_EEE_BIT];
        ctrl.timer_mode_field <= tceoc_pkg::tceoc_mode_t'(w_data[tceoc_pkg::CTRL_MODE_LSB +: 3]);
      end
      if (wr_sel == tceoc_pkg::SEL_CAP) begin
        cap_edges.hi <= tceoc_pkg::tceoc_edge_t'(w_data[tceoc_pkg::EDGE_HI_LSB +: 2]);
        cap_edges.lo <= tceoc_pkg::tceoc_edge_t'(w_data[tceoc_pkg::EDGE_LO_LSB +: 2]);
      end
      if (wr_sel == tceoc_pkg::SEL_EVT) begin
        evt_edges.hi <= tceoc_pkg::tceoc_edge_t'(w_data[tceoc_pkg::EDGE_HI_LSB +: 2]);
        evt_edges.lo <= tceoc_pkg::tceoc_edge_t'(w_data[tceoc_pkg::EDGE_LO_LSB +: 2]);
      end
      if (wr_sel == tceoc_pkg::SEL_OPT) begin
        reg1_capture_select <= w_data[tceoc_pkg::OPT_CCS1_BIT];
        reg0_capture_select <= w_data[tceoc_pkg::OPT_CCS0_BIT];
      end
    end
  end

  // Overflow flag: hardware set beats a software zero write
  // stop clears, a written one is ignored
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      overflow_flag <= 1'b0;
    end else if (!ctrl.counter_enable) begin
      overflow_flag <= 1'b0;
    end else if (ovf_set) begin
      overflow_flag <= 1'b1;
    end else if (ovf_wr_clear) begin
      overflow_flag <= 1'b0;
    end
  end

  // register zero: capture wins over a clashing write
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      capture_compare_zero <= tceoc_pkg::CCR_RESET;
      capture_compare_one  <= tceoc_pkg::CCR_RESET;
    end else begin
      if (cap0_take) begin
        capture_compare_zero <= count;
      end else if (ccr0_wr) begin
        capture_compare_zero <= w_data[CNT_W-1:0];
      end
      if (cap1_take) begin
        capture_compare_one <= count;
      end
    end
  end

  // shadow follows the register, anytime-write style
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      compare0_shadow <= tceoc_pkg::CCR_RESET;
    end else begin
      compare0_shadow <= capture_compare_zero;
    end
  end

  // counter held at zero while stopped
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      count <= tceoc_pkg::CNT_ZERO;
    end else if (!ctrl.counter_enable || cnt_clear) begin
      count <= tceoc_pkg::CNT_ZERO;
    end else if (tick) begin
      count <= count + 1'b1;
    end
  end

  // registered requests and toggling output pin
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      overflow_irq      <= 1'b0;
      compare0_irq      <= 1'b0;
      timer_output_zero <= 1'b0;
    end else begin
      overflow_irq <= ovf_set;
      compare0_irq <= match0;
      if (!ctrl.counter_enable) begin
        timer_output_zero <= 1'b0;
      end else if (match0 && ctrl.out0_enable) begin
        timer_output_zero <= ~timer_output_zero;
      end
    end
  end

  // AXI read: one cycle latency, reads have no side effect
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= tceoc_pkg::RD_ZERO;
      s_axi_rresp   <= tceoc_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= tceoc_pkg::RESP_OKAY;
      s_axi_rdata   <= tceoc_pkg::RD_ZERO;
      case (reg_decode(s_axi_araddr))
        tceoc_pkg::SEL_CTRL: begin
          s_axi_rdata[tceoc_pkg::CTRL_CE_BIT]        <= ctrl.counter_enable;
          s_axi_rdata[tceoc_pkg::CTRL_OE0_BIT]       <= ctrl.out0_enable;
          s_axi_rdata[tceoc_pkg::CTRL_EEE_BIT]       <= ctrl.external_event_input_enable;
          s_axi_rdata[tceoc_pkg::CTRL_MODE_LSB +: 3] <= ctrl.timer_mode_field;
        end
        tceoc_pkg::SEL_CAP:  s_axi_rdata[3:0] <= cap_edges;
        tceoc_pkg::SEL_EVT:  s_axi_rdata[3:0] <= evt_edges;
        tceoc_pkg::SEL_OPT: begin
          s_axi_rdata[tceoc_pkg::OPT_CCS1_BIT] <= reg1_capture_select;
          s_axi_rdata[tceoc_pkg::OPT_CCS0_BIT] <= reg0_capture_select;
          s_axi_rdata[tceoc_pkg::OPT_OVF_BIT]  <= overflow_flag;
        end
        tceoc_pkg::SEL_CCR0:  s_axi_rdata[CNT_W-1:0] <= capture_compare_zero;
        tceoc_pkg::SEL_CCR1:  s_axi_rdata[CNT_W-1:0] <= capture_compare_one;
        tceoc_pkg::SEL_COUNT: s_axi_rdata[CNT_W-1:0] <= count;
        default:              s_axi_rresp <= tceoc_pkg::RESP_SLVERR;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Checks on the design's own behaviour
  property p_ovf_irq_flag;
    @(posedge clk) disable iff (!arst_n) overflow_irq |-> overflow_flag;
  endproperty
  a_ovf_irq_flag: assert property (p_ovf_irq_flag) else $error("irq without flag");

  property p_ovf_modes;
    @(posedge clk) disable iff (!arst_n)
      $rose(overflow_flag) |-> $past(cap_mode) && $past(count) == tceoc_pkg::CNT_MAX;
  endproperty
  a_ovf_modes: assert property (p_ovf_modes) else $error("overflow set wrongly");

  property p_ovf_stop;
    @(posedge clk) disable iff (!arst_n) !ctrl.counter_enable |=> !overflow_flag;
  endproperty
  a_ovf_stop: assert property (p_ovf_stop) else $error("flag kept while stopped");

  property p_ovf_no_sw_set;
    @(posedge clk) disable iff (!arst_n)
      $rose(overflow_flag) |-> $past(ovf_set);
  endproperty
  a_ovf_no_sw_set: assert property (p_ovf_no_sw_set) else $error("flag set by sw");

  property p_cmp_irq;
    @(posedge clk) disable iff (!arst_n)
      compare0_irq |-> $past(count == compare0_shadow) && $past(ctrl.counter_enable);
  endproperty
  a_cmp_irq: assert property (p_cmp_irq) else $error("compare irq without match");

  property p_out_toggle;
    @(posedge clk) disable iff (!arst_n)
      compare0_irq && $past(ctrl.out0_enable) |-> timer_output_zero != $past(timer_output_zero);
  endproperty
  a_out_toggle: assert property (p_out_toggle) else $error("output not toggled");

  property p_cycle_clear;
    @(posedge clk) disable iff (!arst_n)
      match0 && cycle_mode && ctrl.counter_enable |=> count == tceoc_pkg::CNT_ZERO;
  endproperty
  a_cycle_clear: assert property (p_cycle_clear) else $error("cycle not cleared");

  property p_pw_capture;
    @(posedge clk) disable iff (!arst_n)
      cap0_take && pulse_wid |=> count == tceoc_pkg::CNT_ZERO &&
                                 capture_compare_zero == $past(count);
  endproperty
  a_pw_capture: assert property (p_pw_capture) else $error("pulse capture wrong");

  property p_ccr0_cause;
    @(posedge clk) disable iff (!arst_n)
      $changed(capture_compare_zero) |-> $past(cap0_take && cap_mode) || $past(ccr0_wr);
  endproperty
  a_ccr0_cause: assert property (p_ccr0_cause) else $error("register zero changed");

  property p_stop_count;
    @(posedge clk) disable iff (!arst_n)
      !ctrl.counter_enable |=> count == tceoc_pkg::CNT_ZERO;
  endproperty
  a_stop_count: assert property (p_stop_count) else $error("counter ran stopped");

  property p_shadow;
    @(posedge clk) disable iff (!arst_n)
      ccr0_wr && !cap0_take |=> ##1 compare0_shadow == $past(w_data[CNT_W-1:0], 2);
  endproperty
  a_shadow: assert property (p_shadow) else $error("shadow not loaded");

  c_overflow: cover property (@(posedge clk) disable iff (!arst_n) $rose(overflow_flag));
  c_compare:  cover property (@(posedge clk) disable iff (!arst_n) compare0_irq);
  c_pw_cap:   cover property (@(posedge clk) disable iff (!arst_n) cap0_take && pulse_wid);
  c_trigger:  cover property (@(posedge clk) disable iff (!arst_n) trig_edge);

endmodule

// File: verif/tceoc_pin_model.sv
/*
  Far-side model: whatever drives the two timer input pins.
  Assumes the caller enters a task just after a rising clock edge.
*/
`timescale 1ns/100ps
module tceoc_pin_model (
  // Clock
  input  wire logic clk,
  // Pins toward the timer
  output logic      pin_zero,
  output logic      pin_one
);
  // Driven low while idle, never left floating
  initial begin
    pin_zero = 1'b0;
    pin_one  = 1'b0;
  end
  // One pulse on both pins, changed only right after an edge
  task automatic pulse(input int pre, input int high, input int low);
    repeat (pre) @(posedge clk);
    {pin_zero, pin_one} <= 2'b11;
    repeat (high) @(posedge clk);
    {pin_zero, pin_one} <= 2'b00;
    repeat (low) @(posedge clk);
  endtask
endmodule

// File: verif/tb_tceoc_top.sv
/*
  Self-checking bench: registers, capture edges, counting, compare, overflow.
  Assumes the pin model drives the timer inputs and one 20 MHz clock.
*/
`timescale 1ns/100ps
module tb_tceoc_top;
  logic        clk, arst_n, o1;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, v;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        timer_input_zero, timer_input_one, timer_output_zero;
  logic        overflow_irq, compare0_irq;
  int          fail_count, n_compared, n;

  tceoc_top uut (.*);
  tceoc_pin_model pins (.clk(clk), .pin_zero(timer_input_zero), .pin_one(timer_input_one));

  // Free-running clock, 50 ns period
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One bus transfer; address and data stay up until each is taken
  task automatic xfer(input logic wr, input logic [31:0] idx, input logic [31:0] data = 32'h0,
                      input logic [1:0] er = tceoc_pkg::RESP_OKAY);
    @(posedge clk);
    s_axi_awaddr  <= idx << 2;
    s_axi_araddr  <= idx << 2;
    s_axi_wdata   <= data;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{wr}};
    {s_axi_arvalid, s_axi_rready} <= {2{!wr}};
    forever begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_bvalid || s_axi_rvalid) begin
        v = s_axi_rdata;
        check({30'h0, wr ? s_axi_bresp : s_axi_rresp}, {30'h0, er});
        {s_axi_bready, s_axi_rready} <= 2'b00;
        break;
      end
    end
  endtask

  // Stop, edit with zero spare bits, then start
  task automatic cfg(input logic [31:0] ctl, input logic [31:0] idx, input logic [31:0] val,
                     input logic [31:0] ccr0);
    xfer(1'b1, tceoc_pkg::IDX_CTRL, 32'h0);
    xfer(1'b1, tceoc_pkg::IDX_CCR0, ccr0);
    xfer(1'b1, idx, val);
    xfer(1'b1, tceoc_pkg::IDX_CTRL, ctl);
  endtask

  // Bins a capture: none, rising (~45), falling (~65), both (~20)
  function automatic logic [31:0] kind(input logic [31:0] x);
    return (x == 32'h0) ? 32'h0 : (x < 32'h1E) ? 32'h3 : (x < 32'h37) ? 32'h1 : 32'h2;
  endfunction

  task automatic t_regs();
    xfer(1'b0, tceoc_pkg::IDX_CAP_EDGE);
    check(v, 32'h0);
    xfer(1'b0, tceoc_pkg::IDX_EVT_EDGE);
    check(v, 32'h0);
    xfer(1'b0, tceoc_pkg::IDX_OPTION);
    check(v, 32'h0);
    xfer(1'b0, tceoc_pkg::IDX_CCR0);
    check(v, 32'h0);
    xfer(1'b1, tceoc_pkg::IDX_CCR0, 32'h0000ABCD);
    xfer(1'b0, tceoc_pkg::IDX_CCR0);
    check(v, 32'h0000ABCD);
    xfer(1'b0, 32'h0, 32'h0, tceoc_pkg::RESP_SLVERR);
    check(v, 32'h0);
  endtask

  // Pulse-width mode, same edge code on both inputs
  task automatic t_capture();
    for (int c = 0; c < 4; c++) begin
      cfg(32'h86, tceoc_pkg::IDX_CAP_EDGE, 32'(c * 5), 32'h0);
      pins.pulse(40, 20, 10);
      xfer(1'b0, tceoc_pkg::IDX_CCR0);
      check(kind(v), 32'(c));
      xfer(1'b0, tceoc_pkg::IDX_CCR1);
      check(kind(v), 32'(c));
    end
  endtask

  // Capture into register zero outside pulse-width mode only in free-run with its select bit set
  task automatic t_select();
    logic [31:0] ctl [3] = '{32'h80, 32'h85, 32'h85};
    logic [31:0] opt [3] = '{32'h10, 32'h00, 32'h10};
    cfg(32'h0, tceoc_pkg::IDX_CAP_EDGE, 32'h1, 32'h1234);
    for (int i = 0; i < 3; i++) begin
      cfg(ctl[i], tceoc_pkg::IDX_OPTION, opt[i], 32'h1234);
      pins.pulse(10, 10, 10);
      xfer(1'b0, tceoc_pkg::IDX_CCR0);
      check({31'h0, v !== 32'h1234}, 32'(i == 2));
    end
  endtask

  // Event edges counted, then trigger edges restarting the count
  task automatic t_count();
    for (int c = 0; c < 4; c++) begin
      cfg(32'h81, tceoc_pkg::IDX_EVT_EDGE, 32'(c * 4), 32'hFFFF);
      repeat (3) pins.pulse(2, 4, 4);
      xfer(1'b0, tceoc_pkg::IDX_COUNT);
      check(v, (c == 0) ? 32'h0 : (c == 3) ? 32'h6 : 32'h3);
    end
    // Interval mode counting events through the enable bit alone
    cfg(32'hA0, tceoc_pkg::IDX_EVT_EDGE, 32'h4, 32'hFFFF);
    repeat (3) pins.pulse(2, 4, 4);
    xfer(1'b0, tceoc_pkg::IDX_COUNT);
    check(v, 32'h3);
    for (int c = 0; c < 2; c++) begin
      cfg(32'h82, tceoc_pkg::IDX_EVT_EDGE, 32'(c), 32'hFFFF);
      pins.pulse(60, 4, 4);
      xfer(1'b0, tceoc_pkg::IDX_COUNT);
      check({31'h0, v < 32'h1E}, 32'(c));
    end
  endtask

  // Interval period is compare value plus one; output flips each match
  task automatic t_compare();
    cfg(32'hC0, tceoc_pkg::IDX_OPTION, 32'h0, 32'h5);
    do @(posedge clk); while (compare0_irq !== 1'b1);
    o1 = timer_output_zero;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (compare0_irq !== 1'b1);
    check(32'(n), 32'h6);
    check({31'h0, timer_output_zero}, {31'h0, ~o1});
  endtask

  // One full wrap in free-run; long, so run only once
  task automatic t_overflow();
    cfg(32'h85, tceoc_pkg::IDX_OPTION, 32'h0, 32'h0);
    do @(posedge clk); while (overflow_irq !== 1'b1);
    @(posedge clk);
    check({31'h0, overflow_irq}, 32'h0);
    xfer(1'b0, tceoc_pkg::IDX_OPTION);
    check(v, 32'h1);
    xfer(1'b1, tceoc_pkg::IDX_OPTION, 32'h1);
    xfer(1'b0, tceoc_pkg::IDX_OPTION);
    check(v, 32'h1);
    xfer(1'b1, tceoc_pkg::IDX_OPTION, 32'h0);
    xfer(1'b0, tceoc_pkg::IDX_OPTION);
    check(v, 32'h0);
  endtask

  task automatic summarize();
    if (fail_count == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Idle bus, reset for four cycles, then the scenarios
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
    s_axi_wstrb = 4'hF;
    fail_count = 0;
    n_compared = 0;
    arst_n = 1'b0;
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    t_regs();
    t_capture();
    t_select();
    t_count();
    t_compare();
    t_overflow();
    summarize();
  end

  // Run needs about 70000 cycles, mostly the counter wrap
  initial begin
    repeat (90000) @(posedge clk);
    fail_count++;
    summarize();
  end
endmodule
